// file: cxplsm_top.sv
// Top of the link status monitor: lamps, connection test and error counters
module cxplsm_top
    import cxplsm_pkg::*;
#(
    parameter int P_CYC_PER_MS = CYC_PER_MS // Clock cycles per millisecond
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire cxplsm_mode_type i_lamp_operating_mode,
    input wire logic [NUM_CONN-1:0] i_lamp_manual_pattern,
    input wire cxplsm_stat_type [NUM_CONN-1:0] i_stat,
    input wire cxplsm_err_type [NUM_CONN-1:0] i_err,
    output cxplsm_color_type [NUM_CONN-1:0] o_lamp_color,
    input wire logic [NUM_CONN-1:0] i_test_gen_en,
    output logic [NUM_CONN-1:0] o_test_tx_valid,
    output logic [NUM_CONN-1:0][DATA_W-1:0] o_test_tx_data,
    output logic [NUM_CONN-1:0] o_test_tx_last,
    input wire logic [NUM_CONN-1:0] i_test_tx_ready,
    input wire logic [NUM_CONN-1:0] i_test_rx_valid,
    input wire logic [NUM_CONN-1:0][DATA_W-1:0] i_test_rx_data,
    input wire logic [NUM_CONN-1:0] i_test_rx_last,
    input wire logic [1:0] i_connector_selector,
    input wire cxplsm_cnt_type i_counter_selector,
    input wire logic i_counter_clear,
    output logic [CNT_W-1:0] o_counter_value
);
    logic [31:0] cyc_ff; // Cycles within the current millisecond
    logic [MS_W-1:0] ms_ff; // Millisecond within the slow alternate period
    logic ms_tick; // Last cycle of a millisecond
    cxplsm_phase_type phase; // Shared blink phases
    logic [MS_W-1:0] ms_fast; // Position in fast single period
    logic [MS_W-1:0] ms_falt; // Position in fast alternate period
    logic [MS_W-1:0] ms_one; // Position in 1 Hz period
    logic [3:0] tx_idx_ff [NUM_CONN]; // Word index in packet being sent
    logic [DATA_W-1:0] tx_lfsr_ff [NUM_CONN]; // Generator sequence state
    logic [DATA_W-1:0] rx_lfsr_ff [NUM_CONN]; // Checker sequence state
    logic [CNT_W-1:0] cnt_ff [NUM_CONN][NUM_CNT]; // All counters
    logic [NUM_CNT-1:0] inc [NUM_CONN]; // Counter increment requests
    logic [NUM_CONN-1:0] tx_take; // Generator word accepted
    logic [NUM_CONN-1:0] rx_bad; // Received word mismatched
    logic [NUM_CONN-1:0] lamp_err; // Transfer error for the lamp
    logic [CNT_W-1:0] rd_ff; // Registered counter read

    // Millisecond timebase and blink position
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cyc_ff <= '0;
            ms_ff <= '0;
        end else if (ms_tick) begin
            cyc_ff <= '0;
            ms_ff <= (ms_ff == SLOW_ALT_MS - 1'b1) ? '0 : ms_ff + 1'b1;
        end else begin
            cyc_ff <= cyc_ff + 1'b1;
        end
    end
    assign ms_tick = (cyc_ff == 32'(P_CYC_PER_MS - 1));

    // Blink phase decode
    always_comb begin
        ms_fast = ms_ff % FAST_PER_MS;
        ms_falt = ms_ff % FAST_ALT_MS;
        ms_one = ms_ff % ONE_PER_MS;
        phase.fast_single = ms_fast < FAST_ON_MS;
        phase.fast_a = ms_falt < FAST_ON_MS;
        phase.fast_b = (ms_falt >= FAST_PER_MS) && (ms_falt < FAST_PER_MS + FAST_ON_MS);
        phase.fast_end = ms_tick && (ms_fast == FAST_ON_MS - 1'b1);
        phase.one_hz = ms_one < ONE_ON_MS;
        phase.slow_a = ms_ff < SLOW_MS;
        phase.slow_b = (ms_ff >= SLOW_MS * 2) && (ms_ff < SLOW_MS * 3);
    end

    // One lamp per connection
    for (genvar c = 0; c < NUM_CONN; c++) begin : g_lamp
        cxplsm_stat_type st;
        always_comb begin
            st = i_stat[c];
        end
        cxplsm_lamp u_lamp (
            .i_core_clk(i_core_clk),
            .i_rst(i_rst),
            .i_ms_tick(ms_tick),
            .i_phase(phase),
            .i_stat(st),
            .i_err_evt(lamp_err[c]),
            .i_mode(i_lamp_operating_mode),
            .i_manual_bit(i_lamp_manual_pattern[c]),
            .i_test_active(o_test_tx_valid[c]),
            .o_color(o_lamp_color[c])
        );
    end

    // Test generator: sequence words in fixed-length packets
    always_ff @(posedge i_core_clk) begin
        for (int c = 0; c < NUM_CONN; c++) begin
            if (i_rst) begin
                tx_idx_ff[c] <= '0;
                tx_lfsr_ff[c] <= LFSR_SEED;
            end else if (tx_take[c]) begin
                tx_idx_ff[c] <= tx_idx_ff[c] + 1'b1;
                tx_lfsr_ff[c] <= (tx_idx_ff[c] == TEST_LAST_WORD) ? LFSR_SEED : lfsr_next(tx_lfsr_ff[c]);
            end
        end
    end

    // Checker: local sequence restarts after each packet
    always_ff @(posedge i_core_clk) begin
        for (int c = 0; c < NUM_CONN; c++) begin
            if (i_rst) begin
                rx_lfsr_ff[c] <= LFSR_SEED;
            end else if (i_test_rx_valid[c]) begin
                rx_lfsr_ff[c] <= i_test_rx_last[c] ? LFSR_SEED : lfsr_next(rx_lfsr_ff[c]);
            end
        end
    end

    // Generator handshake and increment requests
    always_comb begin
        for (int c = 0; c < NUM_CONN; c++) begin
            o_test_tx_valid[c] = i_test_gen_en[c] || (tx_idx_ff[c] != '0); // Packet always finishes
            o_test_tx_data[c] = tx_lfsr_ff[c];
            o_test_tx_last[c] = (tx_idx_ff[c] == TEST_LAST_WORD);
            tx_take[c] = o_test_tx_valid[c] && i_test_tx_ready[c];
            rx_bad[c] = i_test_rx_valid[c] && (i_test_rx_data[c] != rx_lfsr_ff[c]);
            inc[c] = '0;
            inc[c][CNT_LOCK_LOSS] = i_err[c].lock_loss;
            inc[c][CNT_SYMBOL] = i_err[c].symbol_err;
            inc[c][CNT_DUP_CORR] = i_err[c].dup_corrected;
            inc[c][CNT_DUP_UNCORR] = i_err[c].dup_uncorrected;
            inc[c][CNT_CRC_STREAM] = i_err[c].crc_stream;
            inc[c][CNT_CRC_CONTROL] = i_err[c].crc_control;
            inc[c][CNT_CRC_EVENT] = i_err[c].crc_event;
            inc[c][CNT_TEST_SENT] = tx_take[c] && o_test_tx_last[c];
            inc[c][CNT_TEST_RCVD] = i_test_rx_valid[c] && i_test_rx_last[c];
            inc[c][CNT_TEST_WORD_ERR] = rx_bad[c];
            lamp_err[c] = i_err[c].symbol_err || i_err[c].dup_uncorrected || i_err[c].crc_stream
                          || i_err[c].crc_control || i_err[c].crc_event;
        end
    end

    // Saturating counters; a clear with a same-cycle increment leaves a count of one
    always_ff @(posedge i_core_clk) begin
        for (int c = 0; c < NUM_CONN; c++) begin
            for (int k = 0; k < NUM_CNT; k++) begin
                if (i_rst) begin
                    cnt_ff[c][k] <= '0;
                end else if (i_counter_clear && i_connector_selector == 2'(c)
                             && i_counter_selector == 4'(k)) begin
                    cnt_ff[c][k] <= inc[c][k] ? CNT_W'(1) : '0;
                end else if (inc[c][k] && cnt_ff[c][k] != '1) begin
                    cnt_ff[c][k] <= cnt_ff[c][k] + 1'b1;
                end
            end
        end
    end

    // Counter read through the connector selector
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rd_ff <= '0;
        end else if (i_counter_selector > CNT_TEST_WORD_ERR) begin // Unused index reads zero
            rd_ff <= '0;
        end else begin
            rd_ff <= cnt_ff[i_connector_selector][i_counter_selector];
        end
    end
    assign o_counter_value = rd_ff;

    a_lock_loss_count: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_err[1].lock_loss && !i_counter_clear && cnt_ff[1][CNT_LOCK_LOSS] != '1
        |=> cnt_ff[1][CNT_LOCK_LOSS] == $past(cnt_ff[1][CNT_LOCK_LOSS]) + 1'b1)
        else $error("lock loss not counted");
    a_dup_uncorr_count: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_err[1].dup_uncorrected && !i_counter_clear && cnt_ff[1][CNT_DUP_UNCORR] != '1
        |=> cnt_ff[1][CNT_DUP_UNCORR] == $past(cnt_ff[1][CNT_DUP_UNCORR]) + 1'b1)
        else $error("uncorrected mismatch not counted");
    a_crc_ctrl_count: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !i_err[0].crc_control && !(i_counter_clear && i_connector_selector == 2'd0)
        |=> $stable(cnt_ff[0][CNT_CRC_CONTROL]))
        else $error("control checksum counter moved without cause");
    a_clear_selected: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_counter_clear && i_connector_selector == 2'd1 && i_counter_selector == CNT_SYMBOL
        && !i_err[1].symbol_err && !i_err[1].lock_loss
        |=> cnt_ff[1][CNT_SYMBOL] == '0 && $stable(cnt_ff[1][CNT_LOCK_LOSS]))
        else $error("counter clear misapplied");
    a_sent_packet: assert property (@(posedge i_core_clk) disable iff (i_rst)
        tx_take[0] && o_test_tx_last[0] && !i_counter_clear && cnt_ff[0][CNT_TEST_SENT] != '1
        |=> cnt_ff[0][CNT_TEST_SENT] == $past(cnt_ff[0][CNT_TEST_SENT]) + 1'b1
        && o_test_tx_data[0] == LFSR_SEED)
        else $error("sent packet not counted");
    a_rx_word_err: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_test_rx_valid[0] && i_test_rx_data[0] != rx_lfsr_ff[0] && !i_counter_clear
        && cnt_ff[0][CNT_TEST_WORD_ERR] != '1
        |=> cnt_ff[0][CNT_TEST_WORD_ERR] == $past(cnt_ff[0][CNT_TEST_WORD_ERR]) + 1'b1)
        else $error("word mismatch not counted");
    a_dark_mode: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_lamp_operating_mode == MODE_DARK) [*2] |-> o_lamp_color == '0)
        else $error("lamp lit in dark mode");
    a_manual_bit: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_lamp_operating_mode == MODE_MANUAL |=> o_lamp_color[0]
        == ($past(i_lamp_manual_pattern[0]) ? LAMP_ORANGE : LAMP_OFF))
        else $error("manual lamp bit not followed");
    a_overcurrent_red: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_stat[0].over_current && i_lamp_operating_mode == MODE_STANDARD |=> o_lamp_color[0] == LAMP_RED)
        else $error("over-current not red");
endmodule // cxplsm_top

// file: cxplsm_pkg.sv
// Constants, types and helper functions shared by the link status monitor
package cxplsm_pkg;
    localparam int NUM_CONN = 4; // Connections served
    localparam int CNT_W = 16; // Width of every error and test counter
    localparam int DATA_W = 32; // Test packet word width
    localparam int NUM_CNT = 10; // Counters per connection
    localparam int CLK_HZ = 50_000_000; // Core clock rate
    localparam int CYC_PER_MS = CLK_HZ / 1000; // Cycles in one millisecond
    localparam int MS_W = 12; // Width of millisecond counters
    // Pattern times in milliseconds
    localparam logic [MS_W-1:0] FAST_ON_MS = 12'd20;
    localparam logic [MS_W-1:0] FAST_OFF_MS = 12'd60;
    localparam logic [MS_W-1:0] ONE_ON_MS = 12'd200;
    localparam logic [MS_W-1:0] ONE_OFF_MS = 12'd800;
    localparam logic [MS_W-1:0] SLOW_MS = 12'd1000;
    localparam logic [MS_W-1:0] DET_HOLD_MS = 12'd1000;
    localparam logic [MS_W-1:0] ERR_PULSE_MS = 12'd500;
    localparam logic [MS_W-1:0] FAST_PER_MS = FAST_ON_MS + FAST_OFF_MS;
    localparam logic [MS_W-1:0] FAST_ALT_MS = FAST_PER_MS + FAST_PER_MS;
    localparam logic [MS_W-1:0] ONE_PER_MS = ONE_ON_MS + ONE_OFF_MS;
    localparam logic [MS_W-1:0] SLOW_ALT_MS = SLOW_MS * 12'd4;
    localparam logic [1:0] GREEN_GAP_PULSES = 2'd2; // Green pulses between errors
    localparam logic [3:0] TEST_LAST_WORD = 4'hf; // Sixteen words per test packet
    localparam logic [DATA_W-1:0] LFSR_SEED = 32'hffffffff; // Sequence start
    localparam logic [DATA_W-1:0] LFSR_TAPS = 32'h80200003; // Galois feedback
    // Lamp colours
    typedef enum logic [1:0] {
        LAMP_OFF = 2'b00, LAMP_GREEN = 2'b01, LAMP_ORANGE = 2'b10, LAMP_RED = 2'b11
    } cxplsm_color_type;
    // Software lamp modes
    typedef enum logic [1:0] {
        MODE_STANDARD = 2'b00, MODE_DARK = 2'b01, MODE_ERROR_ONLY = 2'b10, MODE_MANUAL = 2'b11
    } cxplsm_mode_type;
    // Counter index within one connection
    typedef enum logic [3:0] {
        CNT_LOCK_LOSS = 4'h0, CNT_SYMBOL = 4'h1, CNT_DUP_CORR = 4'h2, CNT_DUP_UNCORR = 4'h3,
        CNT_CRC_STREAM = 4'h4, CNT_CRC_CONTROL = 4'h5, CNT_CRC_EVENT = 4'h6,
        CNT_TEST_SENT = 4'h7, CNT_TEST_RCVD = 4'h8, CNT_TEST_WORD_ERR = 4'h9
    } cxplsm_cnt_type;
    // Link state levels of one connection
    typedef struct packed {
        logic detecting; logic poc_active; logic incompatible; logic over_current;
        logic connected; logic waiting_event; logic transferring; logic system_error;
    } cxplsm_stat_type;
    // Receiver error pulses of one connection
    typedef struct packed {
        logic lock_loss; logic symbol_err; logic dup_corrected; logic dup_uncorrected;
        logic crc_stream; logic crc_control; logic crc_event;
    } cxplsm_err_type;
    // Blink phases shared by all lamps
    typedef struct packed {
        logic fast_single; logic fast_a; logic fast_b; logic fast_end;
        logic one_hz; logic slow_a; logic slow_b;
    } cxplsm_phase_type;
    // Next value of the test sequence generator
    function automatic logic [DATA_W-1:0] lfsr_next(input logic [DATA_W-1:0] s);
        lfsr_next = {1'b0, s[DATA_W-1:1]} ^ (s[0] ? LFSR_TAPS : '0);
    endfunction
endpackage

// file: cxplsm_lamp.sv
// One connection lamp: state to colour, hold timers and error pulse spacing
module cxplsm_lamp
    import cxplsm_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ms_tick,
    input wire cxplsm_phase_type i_phase,
    input wire cxplsm_stat_type i_stat,
    input wire logic i_err_evt,
    input wire cxplsm_mode_type i_mode,
    input wire logic i_manual_bit,
    input wire logic i_test_active, // Test packets being sent on this connection
    output cxplsm_color_type o_color
);
    logic [MS_W-1:0] hold_ms_ff; // Detection display hold
    logic det_poc_ff; // Power state seen during detection
    logic det_prev_ff; // Detection level last cycle
    logic [MS_W-1:0] err_ms_ff; // Red pulse time left
    logic pend_ff; // Error waiting to be shown
    logic recov_ff; // Green pulses after a red pulse
    logic lit_seen_ff; // Green lit phase seen in recovery
    logic [1:0] gap_cnt_ff; // Green pulses shown
    cxplsm_color_type color_ff;
    cxplsm_color_type nxt_color;
    logic det_show;
    logic err_start;

    // Lit colour on either half of an alternate pattern
    function automatic cxplsm_color_type pick2(input logic a, input logic b,
                                               input cxplsm_color_type c1,
                                               input cxplsm_color_type c2);
        pick2 = a ? c1 : (b ? c2 : LAMP_OFF);
    endfunction

    assign det_show = i_stat.detecting || (hold_ms_ff != '0);
    // Pulse starts on a tick so it lasts whole milliseconds
    assign err_start = pend_ff && (err_ms_ff == '0) && !recov_ff && i_ms_tick;

    // Detection hold, loaded at detection start
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            hold_ms_ff <= '0;
            det_prev_ff <= 1'b0;
            det_poc_ff <= 1'b0;
        end else begin
            det_prev_ff <= i_stat.detecting;
            if (i_stat.detecting) begin
                det_poc_ff <= i_stat.poc_active;
            end
            if (i_stat.detecting && !det_prev_ff) begin
                hold_ms_ff <= DET_HOLD_MS;
            end else if (i_ms_tick && hold_ms_ff != '0) begin
                hold_ms_ff <= hold_ms_ff - 1'b1;
            end
        end
    end

    // Red error pulse and the green gap that follows it
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            err_ms_ff <= '0;
            pend_ff <= 1'b0;
            recov_ff <= 1'b0;
            lit_seen_ff <= 1'b0;
            gap_cnt_ff <= '0;
        end else begin
            pend_ff <= i_err_evt || (pend_ff && !err_start); // New event beats the clear
            if (err_start) begin
                err_ms_ff <= ERR_PULSE_MS;
            end else if (i_ms_tick && err_ms_ff != '0) begin
                err_ms_ff <= err_ms_ff - 1'b1;
                if (err_ms_ff == 12'd1) begin // Pulse over, start the green gap
                    recov_ff <= 1'b1;
                    gap_cnt_ff <= '0;
                    lit_seen_ff <= 1'b0;
                end
            end else if (recov_ff) begin
                if (i_phase.fast_single) begin
                    lit_seen_ff <= 1'b1;
                end
                if (i_phase.fast_end && lit_seen_ff) begin
                    lit_seen_ff <= 1'b0;
                    gap_cnt_ff <= gap_cnt_ff + 1'b1;
                    if (gap_cnt_ff + 1'b1 == GREEN_GAP_PULSES) begin
                        recov_ff <= 1'b0;
                    end
                end
            end
        end
    end

    // Colour selection by priority, then lamp mode
    always_comb begin
        cxplsm_color_type err_col;
        logic err_on;
        err_on = 1'b1;
        err_col = LAMP_OFF;
        if (i_stat.over_current) begin
            err_col = LAMP_RED;
        end else if (i_stat.system_error) begin
            err_col = i_phase.fast_single ? LAMP_RED : LAMP_OFF;
        end else if (err_ms_ff != '0) begin
            err_col = LAMP_RED;
        end else if (recov_ff) begin
            err_col = i_phase.fast_single ? LAMP_GREEN : LAMP_OFF;
        end else if (i_stat.incompatible) begin
            err_col = pick2(i_phase.slow_a, i_phase.slow_b, LAMP_RED,
                            i_stat.poc_active ? LAMP_GREEN : LAMP_ORANGE);
        end else begin
            err_on = 1'b0;
        end
        nxt_color = err_col; // Off unless an error state wins
        if (!err_on) begin
            if (i_stat.connected && !det_show) begin
                if (i_stat.transferring) begin
                    nxt_color = i_phase.fast_single ? LAMP_GREEN : LAMP_OFF;
                end else if (i_stat.waiting_event) begin
                    nxt_color = i_phase.one_hz ? LAMP_ORANGE : LAMP_OFF;
                end else begin
                    nxt_color = LAMP_GREEN;
                end
            end
            if (det_show) begin
                nxt_color = det_poc_ff ? pick2(i_phase.fast_a, i_phase.fast_b, LAMP_GREEN, LAMP_ORANGE)
                                       : (i_phase.fast_single ? LAMP_ORANGE : LAMP_OFF);
            end
            if (i_test_active) begin // Test traffic beats detection and link state
                nxt_color = pick2(i_phase.slow_a, i_phase.slow_b, LAMP_GREEN, LAMP_ORANGE);
            end
        end
        case (i_mode)
            MODE_STANDARD: nxt_color = nxt_color;
            MODE_DARK: nxt_color = LAMP_OFF;
            MODE_ERROR_ONLY: nxt_color = err_on ? err_col : LAMP_OFF;
            MODE_MANUAL: nxt_color = i_manual_bit ? LAMP_ORANGE : LAMP_OFF;
            default: nxt_color = LAMP_OFF;
        endcase
    end

    // Registered lamp drive
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            color_ff <= LAMP_OFF;
        end else begin
            color_ff <= nxt_color;
        end
    end
    assign o_color = color_ff;

    // Error pulse loads its full length and shows red two cycles after it starts
    a_err_pulse_red: assert property (@(posedge i_core_clk) disable iff (i_rst)
        err_start && i_mode == MODE_STANDARD && !i_stat.over_current && !i_stat.system_error
        |=> (err_ms_ff == ERR_PULSE_MS) ##1 (o_color == LAMP_RED || i_mode != MODE_STANDARD
        || i_stat.over_current || i_stat.system_error))
        else $error("error pulse not shown red");
endmodule // cxplsm_lamp

// file: cxplsm_camera_model.sv
// Camera side of one connection: takes test words, returns test packets
module cxplsm_camera_model
    import cxplsm_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_slow,
    input wire logic i_send,
    input wire logic i_corrupt,
    input wire logic i_tx_valid,
    input wire logic [DATA_W-1:0] i_tx_data,
    input wire logic i_tx_last,
    output logic o_tx_ready,
    output logic [7:0] o_tx_bad,
    output logic o_rx_valid,
    output logic [DATA_W-1:0] o_rx_data,
    output logic o_rx_last
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] tx_seq_ff, rx_seq_ff;
    logic [4:0] rx_idx_ff;
    logic stall_ff;
    // Own copy of the sequence step
    function automatic logic [DATA_W-1:0] step(input logic [DATA_W-1:0] s);
        step = {1'b0, s[DATA_W-1:1]} ^ (s[0] ? LFSR_TAPS : '0);
    endfunction
    // Stalls every other cycle when slow
    assign o_tx_ready = ~(i_slow & stall_ff);
    assign o_rx_valid = (rx_idx_ff != 5'h0);
    assign o_rx_last = (rx_idx_ff == 5'h10);
    // Word three flipped on request; released line shows inverted data
    assign o_rx_data = o_rx_valid ? rx_seq_ff ^ {31'h0, i_corrupt & (rx_idx_ff == 5'h3)} : ~rx_seq_ff;
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            {stall_ff, tx_seq_ff, rx_seq_ff, rx_idx_ff, o_tx_bad} <= {1'b0, LFSR_SEED, LFSR_SEED, 5'h0, 8'h0};
        end else begin
            stall_ff <= ~stall_ff;
            if (i_tx_valid & o_tx_ready) begin
                o_tx_bad <= o_tx_bad + 8'(i_tx_data !== tx_seq_ff);
                tx_seq_ff <= i_tx_last ? LFSR_SEED : step(tx_seq_ff);
            end
            if (o_rx_last) begin
                rx_idx_ff <= 5'h0;
                rx_seq_ff <= LFSR_SEED;
            end else if (o_rx_valid | i_send) begin
                rx_idx_ff <= rx_idx_ff + 5'h1;
                rx_seq_ff <= o_rx_valid ? step(rx_seq_ff) : rx_seq_ff;
            end
        end
    end
endmodule // cxplsm_camera_model

// file: testbench.sv
// Self-checking bench for the link status monitor
module testbench;
    import cxplsm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    cxplsm_mode_type mode = MODE_STANDARD;
    logic [NUM_CONN-1:0] manual = 4'h0, gen_en = 4'h0;
    wire logic [NUM_CONN-1:0] tx_valid, tx_last, tx_ready, rx_valid, rx_last;
    cxplsm_stat_type [NUM_CONN-1:0] stat = '0;
    cxplsm_err_type [NUM_CONN-1:0] err = '0;
    cxplsm_color_type [NUM_CONN-1:0] color;
    wire logic [NUM_CONN-1:0][DATA_W-1:0] tx_data, rx_data;
    logic [1:0] conn_sel = 2'h0;
    cxplsm_cnt_type cnt_sel = CNT_LOCK_LOSS;
    logic cnt_clr = 1'b0, slow = 1'b0, send = 1'b0, corrupt = 1'b0;
    logic [CNT_W-1:0] cnt_val;
    logic [7:0] tx_bad;
    int bad_count = 0, checks_done = 0, sent = 0;
    always #10 i_core_clk = ~i_core_clk;
    cxplsm_top #(.P_CYC_PER_MS(2)) dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_lamp_operating_mode(mode),
        .i_lamp_manual_pattern(manual), .i_stat(stat), .i_err(err), .o_lamp_color(color), .i_test_gen_en(gen_en),
        .o_test_tx_valid(tx_valid), .o_test_tx_data(tx_data), .o_test_tx_last(tx_last), .i_test_tx_ready(tx_ready),
        .i_test_rx_valid(rx_valid), .i_test_rx_data(rx_data), .i_test_rx_last(rx_last),
        .i_connector_selector(conn_sel), .i_counter_selector(cnt_sel), .i_counter_clear(cnt_clr),
        .o_counter_value(cnt_val));
    cxplsm_camera_model cam (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_slow(slow), .i_send(send),
        .i_corrupt(corrupt), .i_tx_valid(tx_valid[0]), .i_tx_data(tx_data[0]), .i_tx_last(tx_last[0]),
        .o_tx_ready(tx_ready[0]), .o_tx_bad(tx_bad), .o_rx_valid(rx_valid[0]), .o_rx_data(rx_data[0]),
        .o_rx_last(rx_last[0]));
    assign {tx_ready[3:1], rx_valid[3:1], rx_last[3:1]} = '0;
    assign rx_data[3:1] = '0;
    // Packets the camera accepted
    always @(posedge i_core_clk) sent += int'(tx_valid[0] & tx_ready[0] & tx_last[0]);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic read_cnt(input logic [1:0] c, input cxplsm_cnt_type k, input logic [31:0] exp);
        @(negedge i_core_clk);
        conn_sel = c;
        cnt_sel = k;
        cnt_clr = 1'b0;
        repeat (2) @(negedge i_core_clk);
        check(32'(cnt_val), exp);
    endtask
    // Counts cycles that one lamp shows a colour
    task automatic count_lit(input int c, input cxplsm_color_type col, input int n, input int exp);
        int lit;
        lit = 0;
        repeat (n) begin
            @(negedge i_core_clk);
            lit += int'(color[c] === col);
        end
        check(32'(lit), 32'(exp));
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge i_core_clk);
        i_rst = 1'b0;
        for (int k = 0; k < 7; k++) begin
            err[1] = 7'(1 << (6 - k));
            @(negedge i_core_clk);
        end
        err[1] = '0;
        for (int k = 0; k < 7; k++) begin
            read_cnt(2'h1, cxplsm_cnt_type'(k), 1);
            read_cnt(2'h2, cxplsm_cnt_type'(k), 0);
        end
        conn_sel = 2'h1;
        cnt_sel = CNT_SYMBOL;
        cnt_clr = 1'b1;
        read_cnt(2'h1, CNT_SYMBOL, 0);
        read_cnt(2'h1, CNT_LOCK_LOSS, 1);
        // Generator and returned packets together, camera stalling
        {slow, send} = 2'b11;
        gen_en[0] = 1'b1;
        @(negedge i_core_clk);
        send = 1'b0;
        repeat (100) @(negedge i_core_clk);
        {corrupt, send} = 2'b11;
        @(negedge i_core_clk);
        {gen_en[0], send} = 2'b00;
        repeat (80) @(negedge i_core_clk);
        corrupt = 1'b0;
        read_cnt(2'h0, CNT_TEST_SENT, 32'(sent));
        check(32'(tx_bad), 0);
        check(32'(sent), 4); // 51 words taken while enabled, fourth packet finishes
        read_cnt(2'h0, CNT_TEST_RCVD, 2);
        read_cnt(2'h0, CNT_TEST_WORD_ERR, 1);
        // Lamp modes
        mode = MODE_MANUAL;
        manual = 4'b0101;
        repeat (3) @(negedge i_core_clk);
        check(32'(color), 32'({LAMP_OFF, LAMP_ORANGE, LAMP_OFF, LAMP_ORANGE}));
        mode = MODE_DARK;
        count_lit(1, LAMP_OFF, 4, 4);
        mode = MODE_STANDARD;
        stat[0] = 8'b0001_0001;
        stat[2] = 8'b0000_1010;
        stat[3] = 8'b0000_0001;
        count_lit(0, LAMP_RED, 160, 160);
        count_lit(2, LAMP_GREEN, 160, 40);
        count_lit(3, LAMP_RED, 160, 40);
        stat[2] = 8'b0000_1100;
        count_lit(2, LAMP_ORANGE, 2000, 400);
        mode = MODE_ERROR_ONLY;
        count_lit(2, LAMP_OFF, 4, 4);
        mode = MODE_STANDARD;
        stat[3] = 8'b0110_0000;
        repeat (2) @(negedge i_core_clk);
        count_lit(3, LAMP_RED, 8000, 2000);
        // One-cycle detection with power, and test traffic that never drains
        stat[2] = 8'b1100_1100;
        gen_en[1] = 1'b1;
        @(negedge i_core_clk);
        stat[2] = 8'b0000_1100;
        fork
            count_lit(3, LAMP_GREEN, 8000, 2000);
            count_lit(1, LAMP_ORANGE, 8000, 2000);
            count_lit(2, LAMP_GREEN, 1920, 240);
        join
        stat[2] = 8'b0000_1000;
        // First error shown at once, second one queued behind it
        fork
            count_lit(2, LAMP_RED, 1150, 1000);
            begin
                err[2] = 7'h04;
                @(negedge i_core_clk);
                err[2] = '0;
                repeat (20) @(negedge i_core_clk);
                err[2] = 7'h04;
                @(negedge i_core_clk);
                err[2] = '0;
            end
        join
        count_lit(2, LAMP_RED, 2000, 1000);
        test_done();
    end
    // Watchdog well past the expected run
    initial begin
        #1_500_000;
        bad_count++;
        test_done();
    end
endmodule // testbench
